// >>> tsr_defs.svh
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
// register byte offsets on the bus
`define TSR_OFF_KEY_N 8'h00
`define TSR_OFF_DATA_N 8'h04
`define TSR_OFF_IDX_N 8'h08
`define TSR_OFF_RND_N 8'h0c
`define TSR_OFF_KEY_W 8'h10
`define TSR_OFF_LO0 8'h14
`define TSR_OFF_LO1 8'h18
`define TSR_OFF_IDX_W 8'h1c
`define TSR_OFF_RND_W 8'h20
`define TSR_OFF_WIRED 8'h24
`define TSR_OFF_CTRL 8'h28
`define TSR_OFF_OP 8'h2c
// writable-bit masks, zero and fill fields drop out
`define TSR_MASK_KEY_N 32'hffff_ffc0
`define TSR_MASK_DATA_N 32'hffff_ff00
`define TSR_MASK_KEY_W 32'hffff_e0ff
`define TSR_MASK_LO_W 32'h3fff_ffff
// narrow layouts
`define TSR_N_VPN 31:12
`define TSR_N_SPACE_IDENTIFIER 11:6
`define TSR_N_PFN 31:12
`define TSR_N_UNC 11
`define TSR_N_WEN 10
`define TSR_N_VAL 9
`define TSR_N_GLB 8
`define TSR_IDX_N 13:8
// wide layouts
`define TSR_W_REG 31:30
`define TSR_W_PAGE_PAIR_NUMBER 29:13
`define TSR_W_SPACE_IDENTIFIER 7:0
`define TSR_W_PFN_LO 25:6
`define TSR_W_COH 5:3
`define TSR_W_WEN 2
`define TSR_W_VAL 1
`define TSR_W_GLB 0
`define TSR_IDX_W 5:0
// shared fields
`define TSR_PROBE 31
`define TSR_VA_OFS 11:0
`define TSR_VA_PAIR 12
`define TSR_CTRL_WIDE 0
`define TSR_OP_FIELD 1:0
// counters and sizes
`define TSR_RND_N_TOP 6'h3f
`define TSR_RND_N_LOW 6'h08
`define TSR_RND_W_TOP 6'h2f
`define TSR_ENTRIES 64
`define TSR_W_ENTRIES 48
`define TSR_WORD_ZERO 32'h0000_0000
`define TSR_RESP_OKAY 1'b0
`endif

// >>> tsr_pkg.sv
`include "tsr_defs.svh"
package tsr_pkg;
  // staging operations started by a write to the op register
  typedef enum logic [1:0] {
    op_read = 2'b00,
    op_write_idx = 2'b01,
    op_write_rnd = 2'b10,
    op_probe = 2'b11
  } tsr_op_type;
  // decoded page coherency attribute
  typedef enum logic [2:0] {
    coh_wt_noalloc = 3'b000,
    coh_wt_alloc = 3'b001,
    coh_uncached = 3'b010,
    coh_write_back = 3'b011,
    coh_reserved = 3'b100
  } tsr_coh_type;
  // one stored entry: key, even data, odd data
  typedef struct packed {
    logic [31:0] key;
    logic [31:0] lo0;
    logic [31:0] lo1;
  } tsr_entry_type;
  // translation request from the core
  typedef struct packed {
    logic req;
    logic store;
    logic [1:0] region;
    logic [31:0] vaddr;
  } tsr_lk_req_type;
  // registered translation answer
  typedef struct packed {
    logic done;
    logic hit;
    logic miss;
    logic invalid;
    logic store_trap;
    logic uncached;
    tsr_coh_type coh;
    logic [31:0] paddr;
  } tsr_lk_res_type;
  // whole state of the block
  typedef struct packed {
    tsr_entry_type [`TSR_ENTRIES-1:0] tlb;
    logic [31:0] key_n;
    logic [31:0] data_n;
    logic [31:0] key_w;
    logic [31:0] lo0;
    logic [31:0] lo1;
    logic probe_n;
    logic [5:0] idx_n;
    logic [5:0] rnd_n;
    logic probe_w;
    logic [5:0] idx_w;
    logic [5:0] rnd_w;
    logic [5:0] wired;
    logic wide;
    logic ap_wr;
    logic ap_rd;
    logic [7:0] ap_addr;
    logic ready;
    logic [31:0] rdata;
    tsr_lk_res_type lk;
  } tsr_state_type;
endpackage

// >>> tsr_regs.sv
// Function
// - narrow key: page 31:12, space 11:6
// - refill miss loads key page number
// - space identifier survives every exception
// - entry read overwrites whole key register
// - narrow data: frame, uncached, wen, valid, global
// - uncached flag one bypasses the cache
// - store through write-disabled entry traps
// - match on invalid entry raises exception
// - global entry matches on page alone
// - narrow zero fields read zero
// - wide key: pair number, region, fill zero
// - wide space identifier is eight bits
// - two wide data registers, even odd
// - wide global needs both pages global
// - coherency field decode, four to seven reserved
// - probe failure sets bit 31
// - wide six-bit index selects entry
// - narrow counter 63 down to 8
// - wide counter read-only, counts retired instructions
// - wide upper bound is 47
// - wide counter reloads on reset, wired write
// - random write uses counter slot
// - wired boundary resets to zero
`timescale 1ns/1ps
`include "tsr_defs.svh"
module tsr_regs (
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic instr_retire, // one valid instruction done
  input wire tsr_pkg::tsr_lk_req_type lk_req, // translation request
  output tsr_pkg::tsr_lk_res_type lk_res // translation answer
);
  tsr_pkg::tsr_state_type s_q; // registered state
  tsr_pkg::tsr_state_type s_d; // next state
  logic [`TSR_ENTRIES-1:0] hit_lk; // lookup match per entry
  logic [`TSR_ENTRIES-1:0] hit_pr; // probe match per entry
  logic any_lk; // some entry matches lookup
  logic any_pr; // some entry matches probe
  logic [5:0] sel_lk; // matching lookup slot
  logic [5:0] sel_pr; // matching probe slot
  logic ap_take; // address phase accepted
  logic op_fire; // op register written
  tsr_pkg::tsr_op_type op_code; // requested op
  logic wired_wr; // wired register written
  logic key_n_touch; // narrow key changed by bus or read op
  logic key_w_touch; // wide key changed by bus or read op
  logic [31:0] rd_val; // read mux
  tsr_pkg::tsr_entry_type ent_lk; // entry hit by lookup
  tsr_pkg::tsr_entry_type ent_idx_n; // entry at narrow index
  tsr_pkg::tsr_entry_type ent_idx_w; // entry at wide index
  logic [31:0] lo_sel; // wide even or odd page data
  logic [2:0] coh_raw; // raw coherency code

  // per-entry compare for lookup and probe
  genvar gi;
  generate
    for (gi = 0; gi < `TSR_ENTRIES; gi++) begin : g_match
      tsr_pkg::tsr_entry_type e; // this entry
      logic n_lk; // narrow lookup match
      logic n_pr; // narrow probe match
      logic w_glb; // both pages global
      logic w_lk; // wide lookup match
      logic w_pr; // wide probe match
      assign e = s_q.tlb[gi];
      // global entry ignores space identifier
      assign n_lk = (e.key[`TSR_N_VPN] == lk_req.vaddr[`TSR_N_VPN]) &&
        (e.lo0[`TSR_N_GLB] || (e.key[`TSR_N_SPACE_IDENTIFIER] == s_q.key_n[`TSR_N_SPACE_IDENTIFIER]));
      assign n_pr = (e.key[`TSR_N_VPN] == s_q.key_n[`TSR_N_VPN]) && e.lo0[`TSR_N_VAL] &&
        (e.lo0[`TSR_N_GLB] || (e.key[`TSR_N_SPACE_IDENTIFIER] == s_q.key_n[`TSR_N_SPACE_IDENTIFIER]));
      // global only when set on both pages
      assign w_glb = e.lo0[`TSR_W_GLB] && e.lo1[`TSR_W_GLB];
      // region and pair number must match
      assign w_lk = (e.key[`TSR_W_REG] == lk_req.region) &&
        (e.key[`TSR_W_PAGE_PAIR_NUMBER] == lk_req.vaddr[`TSR_W_PAGE_PAIR_NUMBER]) &&
        (w_glb || (e.key[`TSR_W_SPACE_IDENTIFIER] == s_q.key_w[`TSR_W_SPACE_IDENTIFIER]));
      assign w_pr = (e.key[`TSR_W_REG] == s_q.key_w[`TSR_W_REG]) &&
        (e.key[`TSR_W_PAGE_PAIR_NUMBER] == s_q.key_w[`TSR_W_PAGE_PAIR_NUMBER]) &&
        (e.lo0[`TSR_W_VAL] || e.lo1[`TSR_W_VAL]) &&
        (w_glb || (e.key[`TSR_W_SPACE_IDENTIFIER] == s_q.key_w[`TSR_W_SPACE_IDENTIFIER]));
      assign hit_lk[gi] = s_q.wide ? ((gi < `TSR_W_ENTRIES) && w_lk) : n_lk;
      assign hit_pr[gi] = s_q.wide ? ((gi < `TSR_W_ENTRIES) && w_pr) : n_pr;
    end
  endgenerate

  // lowest matching slot wins
  always_comb begin
    sel_lk = 6'h00;
    sel_pr = 6'h00;
    for (int i = `TSR_ENTRIES - 1; i >= 0; i--) begin
      if (hit_lk[i]) begin
        sel_lk = 6'(i);
      end
      if (hit_pr[i]) begin
        sel_pr = 6'(i);
      end
    end
  end

  // bus decode and entry taps
  assign any_lk = |hit_lk;
  assign any_pr = |hit_pr;
  assign ap_take = hsel && htrans[1] && hready;
  assign op_fire = s_q.ap_wr && (s_q.ap_addr == `TSR_OFF_OP);
  assign op_code = tsr_pkg::tsr_op_type'(hwdata[`TSR_OP_FIELD]);
  assign wired_wr = s_q.ap_wr && (s_q.ap_addr == `TSR_OFF_WIRED);
  assign ent_lk = s_q.tlb[sel_lk];
  assign ent_idx_n = s_q.tlb[s_q.idx_n];
  assign ent_idx_w = s_q.tlb[s_q.idx_w];
  assign lo_sel = lk_req.vaddr[`TSR_VA_PAIR] ? ent_lk.lo1 : ent_lk.lo0;
  assign coh_raw = lo_sel[`TSR_W_COH];
  assign key_n_touch = (s_q.ap_wr && (s_q.ap_addr == `TSR_OFF_KEY_N)) ||
    (op_fire && (op_code == tsr_pkg::op_read) && !s_q.wide);
  assign key_w_touch = (s_q.ap_wr && (s_q.ap_addr == `TSR_OFF_KEY_W)) ||
    (op_fire && (op_code == tsr_pkg::op_read) && s_q.wide);

  // register read mux, unmapped reads return zero
  always_comb begin
    rd_val = `TSR_WORD_ZERO;
    case (s_q.ap_addr)
      `TSR_OFF_KEY_N: rd_val = s_q.key_n & `TSR_MASK_KEY_N;
      `TSR_OFF_DATA_N: rd_val = s_q.data_n & `TSR_MASK_DATA_N;
      `TSR_OFF_IDX_N: begin
        rd_val[`TSR_PROBE] = s_q.probe_n;
        rd_val[`TSR_IDX_N] = s_q.idx_n;
      end
      `TSR_OFF_RND_N: rd_val = 32'(s_q.rnd_n);
      `TSR_OFF_KEY_W: rd_val = s_q.key_w & `TSR_MASK_KEY_W;
      `TSR_OFF_LO0: rd_val = s_q.lo0 & `TSR_MASK_LO_W;
      `TSR_OFF_LO1: rd_val = s_q.lo1 & `TSR_MASK_LO_W;
      `TSR_OFF_IDX_W: begin
        rd_val[`TSR_PROBE] = s_q.probe_w;
        rd_val[`TSR_IDX_W] = s_q.idx_w;
      end
      `TSR_OFF_RND_W: rd_val = 32'(s_q.rnd_w);
      `TSR_OFF_WIRED: rd_val = 32'(s_q.wired);
      `TSR_OFF_CTRL: rd_val[`TSR_CTRL_WIDE] = s_q.wide;
      default: rd_val = `TSR_WORD_ZERO;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    // bus: reads get one wait state so they see prior writes
    s_d.ap_wr = ap_take && hwrite;
    s_d.ap_rd = ap_take && !hwrite;
    if (ap_take) begin
      s_d.ap_addr = haddr[7:0];
    end
    s_d.ready = !(ap_take && !hwrite);
    if (s_q.ap_rd) begin
      s_d.rdata = rd_val;
    end
    // narrow counter runs every clock, wraps at its low bound
    s_d.rnd_n = (s_q.rnd_n == `TSR_RND_N_LOW) ? `TSR_RND_N_TOP : s_q.rnd_n - 6'h01;
    // wide counter, software cannot write it
    if (wired_wr) begin
      s_d.rnd_w = `TSR_RND_W_TOP;
    end else if (instr_retire) begin
      // never step below the wired entries
      s_d.rnd_w = (s_q.rnd_w <= s_q.wired) ? `TSR_RND_W_TOP : s_q.rnd_w - 6'h01;
    end
    // plain register writes, reserved bits dropped
    if (s_q.ap_wr) begin
      case (s_q.ap_addr)
        `TSR_OFF_KEY_N: s_d.key_n = hwdata & `TSR_MASK_KEY_N;
        `TSR_OFF_DATA_N: s_d.data_n = hwdata & `TSR_MASK_DATA_N;
        `TSR_OFF_IDX_N: s_d.idx_n = hwdata[`TSR_IDX_N];
        `TSR_OFF_KEY_W: s_d.key_w = hwdata & `TSR_MASK_KEY_W;
        `TSR_OFF_LO0: s_d.lo0 = hwdata & `TSR_MASK_LO_W;
        `TSR_OFF_LO1: s_d.lo1 = hwdata & `TSR_MASK_LO_W;
        `TSR_OFF_IDX_W: s_d.idx_w = hwdata[`TSR_IDX_W];
        `TSR_OFF_WIRED: s_d.wired = hwdata[`TSR_IDX_W];
        `TSR_OFF_CTRL: s_d.wide = hwdata[`TSR_CTRL_WIDE];
        default: s_d.wide = s_q.wide; // unmapped or read-only: ignored
      endcase
    end
    // translation answer, registered one cycle after the request
    s_d.lk = '0;
    if (lk_req.req) begin
      s_d.lk.done = 1'b1;
      s_d.lk.hit = any_lk;
      s_d.lk.miss = !any_lk;
      if (any_lk && !s_q.wide) begin
        s_d.lk.invalid = !ent_lk.lo0[`TSR_N_VAL];
        s_d.lk.store_trap = lk_req.store && ent_lk.lo0[`TSR_N_VAL] &&
          !ent_lk.lo0[`TSR_N_WEN];
        s_d.lk.uncached = ent_lk.lo0[`TSR_N_UNC];
        s_d.lk.coh = ent_lk.lo0[`TSR_N_UNC] ? tsr_pkg::coh_uncached : tsr_pkg::coh_write_back;
        s_d.lk.paddr = {ent_lk.lo0[`TSR_N_PFN], lk_req.vaddr[`TSR_VA_OFS]};
      end else if (any_lk) begin
        s_d.lk.invalid = !lo_sel[`TSR_W_VAL];
        s_d.lk.store_trap = lk_req.store && lo_sel[`TSR_W_VAL] && !lo_sel[`TSR_W_WEN];
        // codes four to seven map to reserved, treated as uncached
        s_d.lk.coh = coh_raw[2] ? tsr_pkg::coh_reserved : tsr_pkg::tsr_coh_type'(coh_raw);
        s_d.lk.uncached = coh_raw[2] || (coh_raw == 3'(tsr_pkg::coh_uncached));
        s_d.lk.paddr = {lo_sel[`TSR_W_PFN_LO], lk_req.vaddr[`TSR_VA_OFS]};
      end else if (s_q.wide) begin
        // refill: page fields follow the failed address, identifier kept
        s_d.key_w[`TSR_W_REG] = lk_req.region;
        s_d.key_w[`TSR_W_PAGE_PAIR_NUMBER] = lk_req.vaddr[`TSR_W_PAGE_PAIR_NUMBER];
      end else begin
        s_d.key_n[`TSR_N_VPN] = lk_req.vaddr[`TSR_N_VPN];
      end
    end
    // staging operations
    if (op_fire) begin
      unique case (op_code)
        tsr_pkg::op_read: begin
          if (s_q.wide) begin
            s_d.key_w = ent_idx_w.key & `TSR_MASK_KEY_W;
            s_d.lo0 = ent_idx_w.lo0;
            s_d.lo1 = ent_idx_w.lo1;
          end else begin
            s_d.key_n = ent_idx_n.key & `TSR_MASK_KEY_N;
            s_d.data_n = ent_idx_n.lo0;
          end
        end
        tsr_pkg::op_write_idx: begin
          if (s_q.wide && (s_q.idx_w < 6'(`TSR_W_ENTRIES))) begin
            s_d.tlb[s_q.idx_w] = '{key: s_q.key_w, lo0: s_q.lo0, lo1: s_q.lo1};
          end else if (!s_q.wide) begin
            s_d.tlb[s_q.idx_n] = '{key: s_q.key_n, lo0: s_q.data_n, lo1: `TSR_WORD_ZERO};
          end
        end
        tsr_pkg::op_write_rnd: begin
          if (s_q.wide) begin
            s_d.tlb[s_q.rnd_w] = '{key: s_q.key_w, lo0: s_q.lo0, lo1: s_q.lo1};
          end else begin
            s_d.tlb[s_q.rnd_n] = '{key: s_q.key_n, lo0: s_q.data_n, lo1: `TSR_WORD_ZERO};
          end
        end
        tsr_pkg::op_probe: begin
          if (s_q.wide) begin
            s_d.probe_w = !any_pr;
            if (any_pr) begin
              s_d.idx_w = sel_pr;
            end
          end else begin
            s_d.probe_n = !any_pr;
            if (any_pr) begin
              s_d.idx_n = sel_pr;
            end
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.rnd_n <= `TSR_RND_N_TOP;
      s_q.rnd_w <= `TSR_RND_W_TOP;
      s_q.wired <= 6'h00;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops, hresp tied to okay
  assign hreadyout = s_q.ready;
  assign hresp = `TSR_RESP_OKAY;
  assign hrdata = s_q.rdata;
  assign lk_res = s_q.lk;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_key_n_zero: assert property (s_q.key_n[5:0] == 6'h00)
    else $error("narrow key zero field not zero");
  a_data_n_zero: assert property (s_q.data_n[7:0] == 8'h00)
    else $error("narrow data zero field not zero");
  a_refill_vpn: assert property (s_q.lk.miss && !$past(s_q.wide) && !$past(key_n_touch)
    |-> s_q.key_n[`TSR_N_VPN] == $past(lk_req.vaddr[`TSR_N_VPN]))
    else $error("refill did not load page number");
  a_space_identifier_kept: assert property (!$past(key_n_touch) |-> $stable(s_q.key_n[`TSR_N_SPACE_IDENTIFIER]))
    else $error("space identifier changed without cause");
  a_read_key: assert property (op_fire && op_code == tsr_pkg::op_read && !s_q.wide
    |=> s_q.key_n == ($past(ent_idx_n.key) & `TSR_MASK_KEY_N))
    else $error("entry read did not overwrite key");
  a_uncached_n: assert property (s_q.lk.hit && !$past(s_q.wide)
    |-> s_q.lk.uncached == $past(ent_lk.lo0[`TSR_N_UNC]))
    else $error("uncached flag not followed");
  a_store_trap: assert property (s_q.lk.store_trap |-> $past(lk_req.store) && s_q.lk.hit)
    else $error("store trap without store hit");
  a_invalid: assert property (lk_req.req && any_lk && !s_q.wide && !ent_lk.lo0[`TSR_N_VAL]
    |=> s_q.lk.invalid && s_q.lk.done)
    else $error("invalid entry not flagged");
  a_key_w_fill: assert property (s_q.key_w[12:8] == 5'h00)
    else $error("wide key fill not zero");
  a_coh_rsvd: assert property (s_q.lk.hit && $past(s_q.wide) && $past(coh_raw[2])
    |-> s_q.lk.coh == tsr_pkg::coh_reserved && s_q.lk.uncached)
    else $error("reserved coherency not decoded");
  a_probe_fail: assert property (op_fire && op_code == tsr_pkg::op_probe && !s_q.wide && !any_pr
    |=> s_q.probe_n)
    else $error("probe failure not set");
  a_probe_hit: assert property (op_fire && op_code == tsr_pkg::op_probe && !s_q.wide && any_pr
    |=> !s_q.probe_n && s_q.idx_n == $past(sel_pr))
    else $error("probe hit not recorded");
  a_rnd_n_wrap: assert property (s_q.rnd_n == `TSR_RND_N_LOW |=> s_q.rnd_n == `TSR_RND_N_TOP)
    else $error("narrow counter did not wrap");
  a_rnd_n_range: assert property (s_q.rnd_n >= `TSR_RND_N_LOW)
    else $error("narrow counter below low bound");
  a_rnd_w_hold: assert property (!$past(instr_retire) && !$past(wired_wr) |-> $stable(s_q.rnd_w))
    else $error("wide counter moved without instruction");
  a_rnd_w_top: assert property (s_q.rnd_w <= `TSR_RND_W_TOP)
    else $error("wide counter above upper bound");
  a_wired_load: assert property (wired_wr |=> s_q.rnd_w == `TSR_RND_W_TOP)
    else $error("wired write did not reload counter");
  a_rnd_w_floor: assert property (instr_retire && !wired_wr && s_q.rnd_w <= s_q.wired
    |=> s_q.rnd_w == `TSR_RND_W_TOP)
    else $error("wide counter went below wired bound");
  a_write_rnd: assert property (op_fire && op_code == tsr_pkg::op_write_rnd && !s_q.wide
    |=> s_q.tlb[$past(s_q.rnd_n)].key == $past(s_q.key_n))
    else $error("random write missed counter slot");

  c_probe_hit: cover property (op_fire && op_code == tsr_pkg::op_probe && any_pr);
  c_refill: cover property (s_q.lk.miss ##1 op_fire);
  c_store_trap: cover property (s_q.lk.store_trap);
  c_wide_wrap: cover property (instr_retire && s_q.rnd_w == s_q.wired && s_q.wide);
endmodule // tsr_regs

// >>> tb_tlb_staging_and_replacement_regs.sv
`timescale 1ns/1ps
`include "tsr_defs.svh"
module tb_tlb_staging_and_replacement_regs;
  logic hclk = 1'b0; // bus clock
  logic hresetn = 1'b0; // reset, active low
  logic hsel = 1'b0; // slave select
  logic [31:0] haddr = 32'h0000_0000; // byte address
  logic [1:0] htrans = 2'h0; // idle at start
  logic hwrite = 1'b0; // direction
  logic [31:0] hwdata = 32'h0000_0000; // write data
  logic hreadyout; // slave ready, fed back as hready
  logic hresp; // response, checked once for okay
  logic [31:0] hrdata; // read data
  logic instr_retire = 1'b0; // retire pulse
  tsr_pkg::tsr_lk_req_type lk_req = '0; // lookup request
  tsr_pkg::tsr_lk_res_type lk_res; // lookup answer
  tsr_pkg::tsr_lk_res_type res; // captured answer
  logic [31:0] rd; // captured read word
  int fail_count = 0; // mismatches
  int comparisons = 0; // checks made
  int c; // loop count
  logic [31:0] kw; // wide key under test
  // free running clock
  always #2.5 hclk = ~hclk;
  tsr_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_retire(instr_retire),
    .lk_req(lk_req), .lk_res(lk_res));
  // verdict and end of run
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // word comparison
  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // flag comparison
  task chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  // one single transfer; hready looked at on the settled level before each edge
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      @(posedge hclk);
    end while (ok !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    ahb(1'b0, a, 32'h0);
    chk_word(rd, exp, what);
  endtask
  task op_go(input tsr_pkg::tsr_op_type o);
    wr(`TSR_OFF_OP, {30'h0, o});
  endtask
  // stage a narrow entry and write it to slot i
  task nent(input logic [5:0] i, input logic [31:0] k, input logic [31:0] d);
    wr(`TSR_OFF_IDX_N, {18'h0, i, 8'h0});
    wr(`TSR_OFF_KEY_N, k);
    wr(`TSR_OFF_DATA_N, d);
    op_go(tsr_pkg::op_write_idx);
  endtask
  // one translation, answer taken one cycle later
  task lkup(input logic st, input logic [1:0] rg, input logic [31:0] va);
    lk_req <= '{1'b1, st, rg, va};
    @(posedge hclk);
    lk_req <= '0;
    @(negedge hclk);
    res = lk_res;
    @(posedge hclk);
  endtask
  // retire pulses, one counter step each, reload at the wired bound
  task retire(input int n);
    instr_retire <= 1'b1;
    repeat (n) @(posedge hclk);
    instr_retire <= 1'b0;
  endtask
  task done_test(input string name);
    $display("test %s done, mismatches so far %0d", name, fail_count);
  endtask
  // hang guard
  initial begin
    #100000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`TSR_OFF_RND_W, 32'd47, "wide counter reset");
    rdc(`TSR_OFF_WIRED, 32'h0, "wired reset");
    rdc(8'h30, 32'h0, "unmapped read");
    chk_bit(hresp, 1'b0, "response okay");
    ahb(1'b0, `TSR_OFF_RND_N, 32'h0);
    chk_bit(rd >= 32'd8 && rd <= 32'd63, 1'b1, "narrow counter range");
    done_test("reset");
    wr(`TSR_OFF_KEY_N, 32'hffff_ffff);
    rdc(`TSR_OFF_KEY_N, 32'hffff_ffc0, "narrow key mask");
    wr(`TSR_OFF_DATA_N, 32'hffff_ffff);
    rdc(`TSR_OFF_DATA_N, 32'hffff_ff00, "narrow data mask");
    nent(6'd5, {20'h12345, 6'd3, 6'h0}, 32'habcd_ea00);
    nent(6'd6, {20'h22222, 6'd3, 6'h0}, 32'h1111_1400);
    nent(6'd7, {20'h33333, 6'd3, 6'h0}, 32'h3333_3700);
    lkup(1'b1, 2'h0, 32'h1234_5678);
    chk_bit(res.store_trap, 1'b1, "store trap");
    chk_bit(res.uncached, 1'b1, "uncached");
    chk_word(res.paddr, 32'habcd_e678, "narrow paddr");
    lkup(1'b1, 2'h0, 32'h3333_3abc);
    chk_bit(res.store_trap, 1'b0, "store allowed");
    chk_bit(res.uncached, 1'b0, "cacheable");
    lkup(1'b0, 2'h0, 32'h2222_2000);
    chk_bit(res.invalid, 1'b1, "invalid entry");
    wr(`TSR_OFF_KEY_N, {20'h12345, 6'd7, 6'h0});
    lkup(1'b0, 2'h0, 32'h3333_3000);
    chk_bit(res.hit, 1'b1, "global hit");
    lkup(1'b0, 2'h0, 32'h1234_5000);
    chk_bit(res.miss, 1'b1, "space mismatch");
    lkup(1'b0, 2'h0, 32'h5555_5000);
    rdc(`TSR_OFF_KEY_N, {20'h55555, 6'd7, 6'h0}, "refill key");
    wr(`TSR_OFF_KEY_N, {20'h12345, 6'd3, 6'h0});
    op_go(tsr_pkg::op_probe);
    rdc(`TSR_OFF_IDX_N, {18'h0, 6'd5, 8'h0}, "probe hit");
    wr(`TSR_OFF_KEY_N, {20'h22222, 6'd3, 6'h0});
    op_go(tsr_pkg::op_probe);
    ahb(1'b0, `TSR_OFF_IDX_N, 32'h0);
    chk_bit(rd[31], 1'b1, "probe fail");
    op_go(tsr_pkg::op_write_rnd);
    wr(`TSR_OFF_KEY_N, {20'h0, 6'd9, 6'h0});
    wr(`TSR_OFF_IDX_N, {18'h0, 6'd7, 8'h0});
    op_go(tsr_pkg::op_read);
    rdc(`TSR_OFF_KEY_N, {20'h33333, 6'd3, 6'h0}, "read op key");
    rdc(`TSR_OFF_DATA_N, 32'h3333_3700, "read op data");
    done_test("narrow");
    wr(`TSR_OFF_CTRL, 32'h1);
    wr(`TSR_OFF_WIRED, 32'h4);
    retire(3);
    rdc(`TSR_OFF_RND_W, 32'd44, "retire count");
    wr(`TSR_OFF_RND_W, 32'h0);
    rdc(`TSR_OFF_RND_W, 32'd44, "counter read only");
    retire(41);
    rdc(`TSR_OFF_RND_W, 32'd47, "wrap at wired");
    retire(2);
    wr(`TSR_OFF_WIRED, 32'h4);
    rdc(`TSR_OFF_RND_W, 32'd47, "reload on wired write");
    wr(`TSR_OFF_KEY_W, 32'hffff_ffff);
    rdc(`TSR_OFF_KEY_W, 32'hffff_e0ff, "wide key mask");
    wr(`TSR_OFF_LO0, 32'hffff_ffff);
    rdc(`TSR_OFF_LO0, 32'h3fff_ffff, "even mask");
    kw = {2'b01, 17'h00abc, 5'h0, 8'h21};
    wr(`TSR_OFF_KEY_W, kw);
    wr(`TSR_OFF_LO0, 32'h0000_8016);
    wr(`TSR_OFF_LO1, 32'h0000_c01e);
    op_go(tsr_pkg::op_write_rnd);
    wr(`TSR_OFF_LO0, 32'h0);
    wr(`TSR_OFF_IDX_W, 32'd47);
    op_go(tsr_pkg::op_read);
    rdc(`TSR_OFF_LO0, 32'h0000_8016, "random slot even");
    rdc(`TSR_OFF_LO1, 32'h0000_c01e, "random slot odd");
    lkup(1'b0, 2'b01, {2'b00, 17'h00abc, 1'b1, 12'h0ab});
    chk_word(res.paddr, 32'h0030_00ab, "odd page");
    lkup(1'b0, 2'b01, {2'b00, 17'h00abc, 1'b0, 12'h0ab});
    chk_word(res.paddr, 32'h0020_00ab, "even page");
    lkup(1'b0, 2'b11, {2'b00, 17'h00abc, 1'b0, 12'h0ab});
    chk_bit(res.miss, 1'b1, "region mismatch");
    rdc(`TSR_OFF_KEY_W, {2'b11, 17'h00abc, 5'h0, 8'h21}, "wide refill");
    done_test("wide regs");
    kw = {2'b00, 17'h00055, 5'h0, 8'h09};
    wr(`TSR_OFF_KEY_W, kw);
    wr(`TSR_OFF_IDX_W, 32'd2);
    for (c = 0; c < 8; c++) begin
      wr(`TSR_OFF_LO0, {26'h100, c[2:0], 3'h6});
      op_go(tsr_pkg::op_write_idx);
      lkup(1'b0, 2'b00, {kw[31:12], 12'h123});
      chk_word({29'h0, res.coh}, {29'h0, (c < 4) ? c[2:0] : 3'h4}, "coh");
      chk_bit(res.uncached, c == 2 || c > 3, "coh uncached");
      chk_word(res.paddr, 32'h0010_0123, "wide paddr");
    end
    for (c = 0; c < 2; c++) begin
      wr(`TSR_OFF_KEY_W, kw);
      wr(`TSR_OFF_LO0, 32'h0000_4017);
      wr(`TSR_OFF_LO1, {31'h2003, c[0]});
      op_go(tsr_pkg::op_write_idx);
      wr(`TSR_OFF_KEY_W, {kw[31:8], 8'h0a});
      lkup(1'b0, 2'b00, {kw[31:12], 12'h0});
      chk_bit(res.hit, c[0], "both pages global");
    end
    done_test("wide lookup");
    tally_and_finish;
  end
endmodule // tb_tlb_staging_and_replacement_regs
